// ---- rtl/timer_subsystem_pkg.sv ----
// shared constants and types for the timer subsystem
package timer_subsystem_pkg;
	localparam int unsigned CLK_HZ        = 10_000_000;
	localparam int unsigned RTC_W         = 70;
	localparam int unsigned RTC_CH        = 3;
	localparam int unsigned GT_UNITS      = 4;
	localparam int unsigned NET_W         = 32;
	// register byte offsets
	localparam logic [7:0]  A_CTRL        = 8'h00;
	localparam logic [7:0]  A_RTC_INC     = 8'h04;
	localparam logic [7:0]  A_RTC_CAL     = 8'h08;
	localparam logic [7:0]  A_RTC_LO      = 8'h0C;
	localparam logic [7:0]  A_RTC_MID     = 8'h10;
	localparam logic [7:0]  A_RTC_HI      = 8'h14;
	localparam logic [7:0]  A_RTC_CMP0    = 8'h18;
	localparam logic [7:0]  A_STATUS      = 8'h24;
	localparam logic [7:0]  A_NET         = 8'h28;
	localparam logic [7:0]  A_WDT_LOAD    = 8'h2C;
	localparam logic [7:0]  A_WDT_SVC     = 8'h30;
	localparam logic [7:0]  A_WDT_VAL     = 8'h34;
	localparam logic [7:0]  A_GT_BASE     = 8'h40;
	localparam logic [7:0]  A_GT_STRIDE   = 8'h10;
	// unit sub-offsets: cfg, load, match, value
	localparam logic [3:0]  GT_CFG        = 4'h0;
	localparam logic [3:0]  GT_LOAD       = 4'h4;
	localparam logic [3:0]  GT_MATCH      = 4'h8;
	localparam logic [3:0]  GT_VAL        = 4'hC;
	// control bit positions
	localparam int unsigned C_RTC_EN      = 0;
	localparam int unsigned C_NET_EN      = 1;
	localparam int unsigned C_WDT_EN      = 2;
	localparam int unsigned C_RTC_DBG_RUN = 3;
	// reset values: nominal 32.768 kHz tick adds 1.0 in 16.16
	localparam logic [31:0] RTC_INC_RST   = 32'h0001_0000;
	localparam logic [31:0] WDT_LOAD_RST  = 32'h0000_FFFF;
	localparam logic [31:0] WDT_SVC_KEY   = 32'h1ACC_E551;
	localparam logic [31:0] UNMAPPED_RD   = 32'h0000_0000;
	// mode encoding within a unit config word
	typedef enum logic [2:0] {
		GM_ONESHOT = 3'h0,
		GM_PERIOD  = 3'h1,
		GM_PWM     = 3'h2,
		GM_EDGE_T  = 3'h3,
		GM_EDGE_C  = 3'h4
	} gt_mode_t;
	typedef enum logic [1:0] {
		PM_ACTIVE   = 2'h0,
		PM_IDLE     = 2'h1,
		PM_STANDBY  = 2'h2,
		PM_SHUTDOWN = 2'h3
	} power_mode_t;
	typedef struct packed {
		logic        cyc;
		logic        stb;
		logic        we;
		logic [3:0]  sel;
		logic [7:0]  adr;
		logic [31:0] dat;
	} wb_req_t;
	typedef struct packed {
		logic        ack;
		logic [31:0] dat;
	} wb_rsp_t;
endpackage : timer_subsystem_pkg

// ---- rtl/timer_subsystem.sv ----
// timer subsystem: rtc, general timers, network timer, watchdog
//
// Functional notes
// - 70-bit counter, three channels, low clock.
// - counter runs in all modes except shutdown.
// - calibration trims counter rate for drift.
// - programmable tick increment for other frequencies.
// - counter stops during debug halt by default.
// - four units: 32-bit or two 16-bit.
// - general timers clocked up to 48 MHz; here GT_HZ may not exceed the 10 MHz CLK_HZ.
// - oneshot, periodic, pwm, edge time, edge count; here a split unit's upper half gives no pwm output.
// - timer io wired to event fabric.
// - general timers only active and idle.
// - 32-bit multichannel network timer at 4 MHz; here a single counter with no channels.
// - network timer resyncs to rtc on switching.
// - watchdog interrupts, then resets on failure.
// - watchdog counter clocked at 1.5 MHz.
// - enabled watchdog cannot be disabled until reset.
// - watchdog pauses in standby or debug halt.
// - low clock nominally 32.768 kHz.
// - standby keeps only always-on domain counting; here the network timer is not gated by power mode.
//
// Our own choices: the Wishbone slave port and the address map.
`timescale 1ns/100ps
`default_nettype none
module timer_subsystem
	import timer_subsystem_pkg::*;
#(
	parameter int unsigned GT_HZ  = 10_000_000,
	parameter int unsigned NET_HZ = 4_000_000,
	parameter int unsigned WDT_HZ = 1_500_000
) (
	input  wire logic                 clk_i,
	input  wire logic                 rst_i,
	input  wire logic                 ce_i,
	input  wire wb_req_t              wb_req_i,
	output wb_rsp_t                   wb_rsp_o,
	input  wire logic                 low_freq_sys_clock_i,
	input  wire logic [1:0]           power_mode_i,
	input  wire logic                 debug_halt_i,
	input  wire logic                 radio_on_i,
	input  wire logic [GT_UNITS*2-1:0] event_in_i,
	output logic      [GT_UNITS*2-1:0] event_out_o,
	output logic      [RTC_CH-1:0]    rtc_cmp_o,
	output logic                      wdt_irq_o,
	output logic                      wdt_reset_o
);
	// fractional accumulators turn the fast clock into slower tick rates
	localparam int unsigned PH_W = 32;
	localparam logic [PH_W-1:0] GT_STEP =
		PH_W'((64'(GT_HZ) << 32) / 64'(CLK_HZ));
	localparam logic [PH_W-1:0] NET_STEP =
		PH_W'((64'(NET_HZ) << 32) / 64'(CLK_HZ));
	localparam logic [PH_W-1:0] WDT_STEP =
		PH_W'((64'(WDT_HZ) << 32) / 64'(CLK_HZ));

	initial begin
		if (GT_HZ > 48_000_000 || GT_HZ > CLK_HZ || NET_HZ > CLK_HZ || WDT_HZ > CLK_HZ)
			$error("tick rate must not exceed clock or 48 MHz");
	end

	power_mode_t pm;
	assign pm = power_mode_t'(power_mode_i);
	logic aon_run, periph_run;
	assign aon_run    = ce_i && pm != PM_SHUTDOWN;
	assign periph_run = ce_i && (pm == PM_ACTIVE || pm == PM_IDLE);

	// bus decode
	logic wr, rd_req;
	assign wr     = ce_i && wb_req_i.cyc && wb_req_i.stb && wb_req_i.we && !wb_rsp_o.ack;
	assign rd_req = ce_i && wb_req_i.cyc && wb_req_i.stb && !wb_rsp_o.ack;

	logic [31:0] ctrl, rtc_inc, rtc_cal, wdt_load;
	logic [RTC_W-1:0] rtc_cmp [RTC_CH];

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] sel);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++)
			if (sel[b]) r[b*8 +: 8] = nw[b*8 +: 8];
		return r;
	endfunction : merge

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctrl     <= '0;
			rtc_inc  <= RTC_INC_RST;
			rtc_cal  <= '0;
			wdt_load <= WDT_LOAD_RST;
		end else if (wr) begin
			unique case (wb_req_i.adr)
				A_CTRL: begin
					ctrl <= merge(ctrl, wb_req_i.dat, wb_req_i.sel);
					if (ctrl[C_WDT_EN])
						ctrl[C_WDT_EN] <= 1'b1;
				end
				A_RTC_INC: rtc_inc  <= merge(rtc_inc, wb_req_i.dat, wb_req_i.sel);
				A_RTC_CAL: rtc_cal  <= merge(rtc_cal, wb_req_i.dat, wb_req_i.sel);
				A_WDT_LOAD: wdt_load <= merge(wdt_load, wb_req_i.dat, wb_req_i.sel);
				default: ;
			endcase
		end
	end

	// rtc: 70-bit counter, low 16 bits a fraction, advances per low clock rise
	logic lf_q, lf_rise;
	logic [RTC_W-1:0] rtc;
	always_ff @(posedge clk_i) begin
		if (rst_i)
			lf_q <= 1'b0;
		else if (ce_i)
			lf_q <= low_freq_sys_clock_i;
	end
	assign lf_rise = low_freq_sys_clock_i && !lf_q;

	logic rtc_go;
	logic [RTC_W-1:0] rtc_step;
	assign rtc_step = rtc + RTC_W'(rtc_inc);
	assign rtc_go = aon_run && ctrl[C_RTC_EN] && lf_rise &&
		(!debug_halt_i || ctrl[C_RTC_DBG_RUN]);
	always_ff @(posedge clk_i) begin
		if (rst_i)
			rtc <= '0;
		else if (rtc_go)
			rtc <= rtc_step + {{(RTC_W-32){rtc_cal[31]}}, rtc_cal};
	end

	// compare channels
	genvar gc;
	generate
		for (gc = 0; gc < RTC_CH; gc++) begin : g_cmp
			logic [7:0] base;
			assign base = A_RTC_CMP0 + 8'(gc * 4);
			always_ff @(posedge clk_i) begin
				if (rst_i)
					rtc_cmp[gc] <= '1;
				else if (wr && wb_req_i.adr == base)
					rtc_cmp[gc] <= {wb_req_i.dat[RTC_W-39:0], 32'h0000_0000, 6'h00};
			end
			always_ff @(posedge clk_i) begin
				if (rst_i)
					rtc_cmp_o[gc] <= 1'b0;
				else if (ce_i)
					rtc_cmp_o[gc] <= rtc_go && rtc[RTC_W-1:16] < rtc_cmp[gc][RTC_W-1:16] &&
						rtc_step[RTC_W-1:16] >= rtc_cmp[gc][RTC_W-1:16];
			end
		end
	endgenerate

	// network timer, 4 MHz by phase accumulator, reloaded from rtc on radio switch
	logic [PH_W-1:0] net_ph, wdt_ph;
	logic [NET_W-1:0] net;
	logic radio_q, net_tick;
	assign net_tick = (net_ph + NET_STEP) < net_ph;
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			net_ph  <= '0;
			net     <= '0;
			radio_q <= 1'b0;
		end else if (ce_i) begin
			radio_q <= radio_on_i;
			net_ph  <= net_ph + NET_STEP;
			if (radio_on_i != radio_q)
				net <= NET_W'((rtc[RTC_W-1:16] * 64'd4_000_000) >> 15);
			else if (radio_on_i && ctrl[C_NET_EN] && net_tick)
				net <= net + 32'h0000_0001;
		end
	end
	// crystal source is a software precondition

	// watchdog
	logic [31:0] wdt;
	logic wdt_tick, svc;
	assign wdt_tick = (wdt_ph + WDT_STEP) < wdt_ph;
	assign svc = wr && wb_req_i.adr == A_WDT_SVC && wb_req_i.dat == WDT_SVC_KEY;
	logic wdt_run;
	assign wdt_run = aon_run && pm != PM_STANDBY && !debug_halt_i && ctrl[C_WDT_EN];
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wdt_ph      <= '0;
			wdt         <= WDT_LOAD_RST;
			wdt_irq_o   <= 1'b0;
			wdt_reset_o <= 1'b0;
		end else if (ce_i) begin
			if (wdt_run)
				wdt_ph <= wdt_ph + WDT_STEP;
			if (wdt_run && wdt_tick && wdt == '0) begin
				wdt <= wdt_load;
				if (wdt_irq_o)
					wdt_reset_o <= 1'b1;
				wdt_irq_o <= 1'b1;
			end else begin
				if (svc) begin
					wdt       <= wdt_load;
					wdt_irq_o <= 1'b0;
				end else if (wdt_run && wdt_tick)
					wdt <= wdt - 32'h0000_0001;
			end
		end
	end

	// general timer units, 16-bit halves a and b
	logic [31:0] gt_cfg [GT_UNITS];
	logic [31:0] gt_val [GT_UNITS];
	logic [PH_W-1:0] gt_ph;
	logic gt_tick;
	assign gt_tick = GT_HZ == CLK_HZ || (gt_ph + GT_STEP) < gt_ph;
	always_ff @(posedge clk_i) begin
		if (rst_i)
			gt_ph <= '0;
		else if (periph_run)
			gt_ph <= gt_ph + GT_STEP;
	end
	logic [2*GT_UNITS-1:0] ev_q;
	always_ff @(posedge clk_i) begin
		if (rst_i)
			ev_q <= '0;
		else if (ce_i)
			ev_q <= event_in_i;
	end

	genvar gu;
	generate
		for (gu = 0; gu < GT_UNITS; gu++) begin : g_unit
			logic [31:0] load, match, cnt, cap;
			logic [1:0]  done;
			logic        split, en;
			gt_mode_t    mode;
			logic [7:0]  base;
			assign base  = A_GT_BASE + 8'(gu) * A_GT_STRIDE;
			assign en    = gt_cfg[gu][0];
			assign split = gt_cfg[gu][1];
			assign mode  = gt_mode_t'(gt_cfg[gu][4:2]);
			assign gt_val[gu] = (mode == GM_EDGE_T) ? cap : cnt;
			always_ff @(posedge clk_i) begin
				if (rst_i) begin
					gt_cfg[gu] <= '0;
					load       <= '0;
					match      <= '0;
				end else if (wr && wb_req_i.adr[7:4] == base[7:4]) begin
					unique case (wb_req_i.adr[3:0])
						GT_CFG:   gt_cfg[gu] <= merge(gt_cfg[gu], wb_req_i.dat, wb_req_i.sel);
						GT_LOAD:  load  <= merge(load, wb_req_i.dat, wb_req_i.sel);
						GT_MATCH: match <= merge(match, wb_req_i.dat, wb_req_i.sel);
						default: ;
					endcase
				end
			end
			// oneshot, periodic and pwm halves count down from the load, edge modes count up; split halves run independently
			for (genvar h = 0; h < 2; h++) begin : g_half
				localparam int unsigned LO = h * 16;
				logic edge_in, tick, zero;
				logic [31:0] m;
				assign m       = split ? 32'h0000_FFFF : 32'hFFFF_FFFF;
				// unsplit upper half follows the lower half's edges and tick
				assign edge_in = split ? event_in_i[gu*2+h] && !ev_q[gu*2+h] :
					event_in_i[gu*2] && !ev_q[gu*2];
				assign zero    = split ? cnt[LO +: 16] == 16'h0000 : cnt == '0;
				assign tick    = periph_run && en && gt_tick;
				always_ff @(posedge clk_i) begin
					if (rst_i) begin
						done[h] <= 1'b0;
					end else if (tick && mode == GM_ONESHOT && zero)
						done[h] <= 1'b1;
					else if (wr && wb_req_i.adr == base + 8'(GT_CFG))
						done[h] <= 1'b0;
				end
				always_ff @(posedge clk_i) begin
					if (rst_i) begin
						cnt[LO +: 16] <= '0;
						cap[LO +: 16] <= '0;
					end else if (tick) begin
						unique case (mode)
							GM_EDGE_C: if (edge_in) cnt[LO +: 16] <= split ?
								cnt[LO +: 16] + 16'h0001 : 16'((cnt + 32'h1) >> LO);
							GM_EDGE_T: begin
								cnt[LO +: 16] <= split ? cnt[LO +: 16] + 16'h0001 :
									16'((cnt + 32'h1) >> LO);
								if (edge_in) cap[LO +: 16] <= cnt[LO +: 16];
							end
							GM_ONESHOT: if (!zero) cnt[LO +: 16] <= split ?
								cnt[LO +: 16] - 16'h0001 : 16'((cnt - 32'h1) >> LO);
							default: cnt[LO +: 16] <= zero ? load[LO +: 16] : (split ?
								cnt[LO +: 16] - 16'h0001 : 16'((cnt - 32'h1) >> LO));
						endcase
					end else if (wr && wb_req_i.adr == base + 8'(GT_LOAD))
						cnt[LO +: 16] <= wb_req_i.dat[LO +: 16];
				end
				always_ff @(posedge clk_i) begin
					if (rst_i)
						event_out_o[gu*2+h] <= 1'b0;
					else if (ce_i)
						event_out_o[gu*2+h] <= (mode == GM_PWM) ?
							((cnt & m) >> LO) > ((match & m) >> LO) :
							tick && zero;
				end
			end
		end
	endgenerate

	// read mux and ack
	logic [31:0] rd;
	always_comb begin
		rd = UNMAPPED_RD;
		unique case (wb_req_i.adr)
			A_CTRL:     rd = ctrl;
			A_RTC_INC:  rd = rtc_inc;
			A_RTC_CAL:  rd = rtc_cal;
			A_RTC_LO:   rd = rtc[31:0];
			A_RTC_MID:  rd = rtc[63:32];
			A_RTC_HI:   rd = {26'h0, rtc[69:64]};
			A_STATUS:   rd = {26'h0, wdt_reset_o, wdt_irq_o, 1'b0, rtc_cmp_o};
			A_NET:      rd = net;
			A_WDT_LOAD: rd = wdt_load;
			A_WDT_VAL:  rd = wdt;
			default: begin
				if (wb_req_i.adr >= A_GT_BASE)
					for (int u = 0; u < GT_UNITS; u++)
						if (wb_req_i.adr[7:4] == 4'(u + 4))
							rd = wb_req_i.adr[3:0] == GT_CFG ? gt_cfg[u] : gt_val[u];
			end
		endcase
	end
	always_ff @(posedge clk_i) begin
		if (rst_i)
			wb_rsp_o <= '0;
		else if (ce_i) begin
			wb_rsp_o.ack <= rd_req;
			wb_rsp_o.dat <= rd;
		end
	end

	AST_WDT_LOCK: assert property (@(posedge clk_i) disable iff (rst_i)
		ctrl[C_WDT_EN] |=> ctrl[C_WDT_EN]) else $error("watchdog disabled");
	AST_WDT_SEQ: assert property (@(posedge clk_i) disable iff (rst_i)
		$rose(wdt_reset_o) |-> $past(wdt_irq_o)) else $error("reset without irq");
	AST_RTC_HALT: assert property (@(posedge clk_i) disable iff (rst_i)
		debug_halt_i && !ctrl[C_RTC_DBG_RUN] |=> $stable(rtc)) else $error("rtc moved");
	AST_RTC_OFF: assert property (@(posedge clk_i) disable iff (rst_i)
		pm == PM_SHUTDOWN |=> $stable(rtc)) else $error("rtc in shutdown");
	AST_WDT_PAUSE: assert property (@(posedge clk_i) disable iff (rst_i)
		pm == PM_STANDBY && !svc |=> $stable(wdt)) else $error("wdt ran");
	AST_ACK: assert property (@(posedge clk_i) disable iff (rst_i)
		ce_i && wb_req_i.cyc && wb_req_i.stb && !wb_rsp_o.ack |=> wb_rsp_o.ack)
		else $error("no ack");
	AST_GT_STBY: assert property (@(posedge clk_i) disable iff (rst_i)
		pm == PM_STANDBY |-> !g_unit[0].g_half[0].tick) else $error("timer in standby");
	AST_NET_SYNC: assert property (@(posedge clk_i) disable iff (rst_i)
		ce_i && radio_on_i != radio_q |=> net == NET_W'(($past(rtc[RTC_W-1:16]) *
		64'd4_000_000) >> 15)) else $error("net not resynced");
endmodule : timer_subsystem
`default_nettype wire

// ---- verification/timer_subsystem_tb.sv ----
// self-checking bench for the timer subsystem
`timescale 1ns/100ps
`default_nettype none
module timer_subsystem_tb
	import timer_subsystem_pkg::*;
;
	typedef struct packed {
		logic [31:0] e;
		logic [31:0] m;
	} note_t;
	logic        clk_i;
	logic        rst_i;
	logic        ce_i;
	logic        lf;
	logic        halt;
	logic        radio;
	logic [1:0]  pm;
	wb_req_t     req;
	wb_rsp_t     rsp;
	logic [7:0]  ev_in;
	logic [7:0]  ev_out;
	logic [2:0]  cmp;
	logic        irq;
	logic        wrst;
	logic [31:0] q;
	logic [31:0] a0;
	logic [31:0] seed;
	note_t       nt;
	note_t       notes[$];
	int          n_errors = 0;
	int          cmp_count = 0;
	int          cyc = 0;
	int          cnt;

	timer_subsystem #(.GT_HZ(10_000_000), .NET_HZ(4_000_000), .WDT_HZ(1_500_000)) u_timer_subsystem (
		.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .wb_req_i(req), .wb_rsp_o(rsp),
		.low_freq_sys_clock_i(lf), .power_mode_i(pm), .debug_halt_i(halt),
		.radio_on_i(radio), .event_in_i(ev_in), .event_out_o(ev_out), .rtc_cmp_o(cmp),
		.wdt_irq_o(irq), .wdt_reset_o(wrst));

	initial begin
		clk_i = 1'b0;
		forever #50 clk_i = ~clk_i;
	end

	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] t;
		t = s ^ (s << 13);
		t = t ^ (t >> 17);
		return t ^ (t << 5);
	endfunction : xs

	task automatic conclude();
		$display("compares %0d errors %0d", cmp_count, n_errors);
		if (n_errors == 0 && cmp_count > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : conclude

	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			n_errors++;
			$display("BAD %s exp %h seen %h", nm, exp, seen);
		end
	endtask : check

	// classic single cycle; request held until ack is sampled
	task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
		int k;
		k = 0;
		@(posedge clk_i);
		req <= '{cyc: 1'b1, stb: 1'b1, we: we, sel: 4'hF, adr: a, dat: d};
		do begin
			@(posedge clk_i);
			k++;
		end while (rsp.ack !== 1'b1 && k < 50);
		if (k >= 50) begin
			n_errors++;
			conclude();
		end
		q = rsp.dat;
		req <= '0;
	endtask : wb

	task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
		notes.push_back('{e: e, m: m});
		wb(1'b0, a, 32'h0000_0000);
	endtask : rd

	// slow clock ticks, long enough to survive any input synchroniser
	task automatic lft(input int n);
		repeat (n) begin
			@(posedge clk_i);
			lf <= 1'b1;
			repeat (3) @(posedge clk_i);
			lf <= 1'b0;
			repeat (3) @(posedge clk_i);
		end
	endtask : lft

	task automatic pulses(output int n);
		n = 0;
		repeat (200) begin
			@(posedge clk_i);
			if (ev_out[0] === 1'b1) n++;
		end
	endtask : pulses

	// read results are judged here, oldest note first
	always @(posedge clk_i) begin
		if (rsp.ack === 1'b1 && req.we === 1'b0 && notes.size() > 0) begin
			nt = notes.pop_front();
			check("read data", rsp.dat & nt.m, nt.e & nt.m);
		end
	end

	always @(posedge clk_i) begin
		cyc <= cyc + 1;
		if (cyc == 60000) begin
			n_errors++;
			conclude();
		end
	end

	initial begin
		rst_i = 1'b1;
		ce_i = 1'b1;
		lf = 1'b0;
		halt = 1'b0;
		radio = 1'b0;
		pm = PM_ACTIVE;
		req = '0;
		ev_in = 8'h00;
		seed = 32'h0000_002A;
		repeat (10) @(posedge clk_i);
		rst_i <= 1'b0;
		check("outputs", {19'h0, ev_out, cmp, irq, wrst}, 32'h0);
		rd(A_RTC_INC, RTC_INC_RST, 32'hFFFF_FFFF);
		rd(A_WDT_LOAD, WDT_LOAD_RST, 32'hFFFF_FFFF);
		wb(1'b1, 8'hFC, 32'hFFFF_FFFF);
		rd(8'hFC, UNMAPPED_RD, 32'hFFFF_FFFF);
		wb(1'b1, A_CTRL, 32'h0000_0001);
		lft(5);
		rd(A_RTC_LO, 32'h0005_0000, 32'hFFFF_FFFF);
		halt <= 1'b1;
		lft(3);
		rd(A_RTC_LO, 32'h0005_0000, 32'hFFFF_FFFF);
		halt <= 1'b0;
		pm <= PM_SHUTDOWN;
		lft(3);
		rd(A_RTC_LO, 32'h0005_0000, 32'hFFFF_FFFF);
		pm <= PM_STANDBY;
		lft(2);
		rd(A_RTC_LO, 32'h0007_0000, 32'hFFFF_FFFF);
		pm <= PM_ACTIVE;
		wb(1'b1, A_RTC_INC, 32'h0002_0000);
		wb(1'b1, A_RTC_CAL, 32'h0000_0003);
		lft(2);
		rd(A_RTC_LO, 32'h000B_0006, 32'hFFFF_FFFF);
		wb(1'b1, A_CTRL, 32'h0000_0009);
		halt <= 1'b1;
		lft(1);
		halt <= 1'b0;
		rd(A_RTC_LO, 32'h000D_0009, 32'hFFFF_FFFF);
		rd(A_RTC_MID, 32'h0, 32'hFFFF_FFFF);
		rd(A_RTC_HI, 32'h0, 32'h0000_003F);
		// network timer: about 41 counts across 103 cycles at 4 MHz
		// bench clock stands in for the crystal source
		wb(1'b1, A_CTRL, 32'h0000_0003);
		radio <= 1'b1;
		repeat (10) @(posedge clk_i);
		rd(A_NET, 32'h0, 32'h0);
		a0 = q;
		repeat (100) @(posedge clk_i);
		rd(A_NET, 32'h0, 32'h0);
		check("net rate", {31'h0, (q - a0 >= 32'd40) && (q - a0 <= 32'd42)}, 32'h1);
		// watchdog: interrupt, service, lock, pause, then reset
		wb(1'b1, A_WDT_LOAD, 32'h0000_0040);
		wb(1'b1, A_CTRL, 32'h0000_0004);
		// counter still holds its reset load; a service pulls in the short one
		wb(1'b1, A_WDT_SVC, WDT_SVC_KEY);
		cnt = 0;
		while (irq !== 1'b1 && cnt < 1000) begin
			@(posedge clk_i);
			cnt++;
		end
		check("wdt irq", {30'h0, irq, wrst}, 32'h2);
		wb(1'b1, A_WDT_SVC, WDT_SVC_KEY);
		rd(A_STATUS, 32'h0, 32'h0000_0030);
		wb(1'b1, A_CTRL, 32'h0000_0000);
		rd(A_CTRL, 32'h0000_0004, 32'h0000_0004);
		halt <= 1'b1;
		repeat (3) @(posedge clk_i);
		rd(A_WDT_VAL, 32'h0, 32'h0);
		a0 = q;
		repeat (60) @(posedge clk_i);
		rd(A_WDT_VAL, a0, 32'hFFFF_FFFF);
		halt <= 1'b0;
		pm <= PM_STANDBY;
		repeat (60) @(posedge clk_i);
		rd(A_WDT_VAL, a0, 32'hFFFF_FFFF);
		pm <= PM_ACTIVE;
		cnt = 0;
		while (wrst !== 1'b1 && cnt < 2000) begin
			@(posedge clk_i);
			cnt++;
		end
		check("wdt reset", {30'h0, irq, wrst}, 32'h3);
		rst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		check("wdt reset cleared", {31'h0, wrst}, 32'h0);
		rd(A_CTRL, 32'h0, 32'h0000_0004);
		// general timer unit 0 periodic with load 9
		wb(1'b1, A_GT_BASE + {4'h0, GT_LOAD}, 32'h0000_0009);
		wb(1'b1, A_GT_BASE + {4'h0, GT_CFG}, 32'h0000_0005);
		pulses(cnt);
		check("periodic", {31'h0, cnt >= 15 && cnt <= 25}, 32'h1);
		pm <= PM_STANDBY;
		repeat (5) @(posedge clk_i);
		pulses(cnt);
		check("standby", cnt, 32'h0);
		pm <= PM_IDLE;
		pulses(cnt);
		check("idle", {31'h0, cnt > 0}, 32'h1);
		pm <= PM_ACTIVE;
		// unit 1 edge count with a random number of edges
		seed = xs(seed);
		wb(1'b1, A_GT_BASE + A_GT_STRIDE + {4'h0, GT_LOAD}, 32'h0);
		wb(1'b1, A_GT_BASE + A_GT_STRIDE + {4'h0, GT_CFG}, 32'h0000_0011);
		repeat (int'(seed[2:0]) + 1) begin
			ev_in[2] <= 1'b1;
			repeat (2) @(posedge clk_i);
			ev_in[2] <= 1'b0;
			repeat (2) @(posedge clk_i);
		end
		rd(A_GT_BASE + A_GT_STRIDE + {4'h0, GT_VAL}, {28'h0, {1'b0, seed[2:0]} + 4'h1}, 32'hFFFF);
		// every mode code with the split bit, unit left disabled
		for (int i = 0; i < 5; i++) begin
			wb(1'b1, A_GT_BASE + 8'h20, {27'h0, i[2:0], 2'b10});
			rd(A_GT_BASE + 8'h20, {27'h0, i[2:0], 2'b10}, 32'h0000_001F);
		end
		repeat (3) @(posedge clk_i);
		conclude();
	end
endmodule : timer_subsystem_tb
`default_nettype wire
